// *** addr_core.sv ***
// Program counter, pointer registers, RAM address buffer and RAM stack engine.
// Assumes the sequencer issues one command while cmd_ready is high and the
// program ROM returns rom_data one clock after fetch_addr changes.
`timescale 1ns/1ps

// Summary of operation
// - Twelve-bit counter holds next fetch address
// - Advance by length, or load on transfers
// - Reset clears counter to zero
// - Upper six bits page, lower six word
// - In-page branch replaces lower six bits
// - Last-word branch uses incremented upper bits
// - Call pushes counter advanced by length, loads eleven-bit target
// - Table read returns high or low nibble
// - Lookup byte from pointed nibble plus carry
// - Interrupts load fixed vectors 002 to 00C
// - Small ROM ignores counter top bit
// - Blank ROM reads zero, a no-op
// - Page and word pointer registers, four bits
// - Word pointer selects one of sixteen pins
// - Address buffer is sole RAM address source
// - Save address and flags in four nibbles
// - Return restores counter; interrupt return adds flags
// - Level decremented after save, incremented before restore
// - Stack-level word at FF sets pointer
// - Table pointer in nibbles FC, FD, FE
module addr_core
    import addr_core_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // Variant strap: high for the 2K-byte program memory
    input  wire logic                 rom_2k,
    // Command from the instruction sequencer
    input  wire logic                 cmd_valid,
    input  wire logic [3:0]           cmd_code,
    input  wire logic [PC_W-1:0]      cmd_operand,
    input  wire logic [1:0]           cmd_len,
    input  wire logic                 cmd_cond,
    input  wire logic [2:0]           irq_src,
    input  wire logic [NIB_W-1:0]     cmd_wdata,
    input  wire logic                 cmd_write,
    input  wire logic [NIB_W-1:0]     flags_in,
    output logic                      cmd_ready,
    // Program memory
    output logic [PC_W-1:0]           fetch_addr,
    input  wire logic [ROM_DW-1:0]    rom_data,
    // Counter and pointers
    output logic [PC_W-1:0]           next_instr_counter,
    output logic [NIB_W-1:0]          page_select_reg,
    output logic [NIB_W-1:0]          word_select_reg,
    output logic [RAM_AW-1:0]         ram_addr_buffer,
    output logic [PORT_BITS-1:0]      port_bit_sel,
    // Results
    output logic [NIB_W-1:0]          acc_data,
    output logic                      acc_load,
    output logic [ROM_DW-1:0]         lookup_byte_out,
    output logic                      lookup_load,
    output logic [NIB_W-1:0]          flags_out,
    output logic                      flags_load,
    output logic [NIB_W-1:0]          mem_rdata,
    output logic                      mem_done
);
    ram_if ram ();

    state_t              state_q, state_d;
    cmd_t                op_q, op_d;
    logic [1:0]          idx_q, idx_d;
    logic [PC_W-1:0]     pc_q, pc_d;
    logic [PC_W-1:0]     target_q, target_d;
    logic [15:0]         stk_q, stk_d;
    logic [NIB_W-1:0]    level_q, level_d;
    logic [PC_W-1:0]     dc_q, dc_d;
    logic [RAM_AW-1:0]   buf_q, buf_d;
    logic [NIB_W-1:0]    page_q, page_d;
    logic [NIB_W-1:0]    word_q, word_d;
    logic                wr_q, wr_d;
    logic [NIB_W-1:0]    wdata_q, wdata_d;
    logic                carry_q, carry_d;
    logic [PC_W-1:0]     rom_addr_q, rom_addr_d;
    logic [NIB_W-1:0]    acc_q, acc_d;
    logic                acc_ld_q, acc_ld_d;
    logic [ROM_DW-1:0]   lut_q, lut_d;
    logic                lut_ld_q, lut_ld_d;
    logic [NIB_W-1:0]    flg_q, flg_d;
    logic                flg_ld_q, flg_ld_d;
    logic [NIB_W-1:0]    mrd_q, mrd_d;
    logic                mdone_q, mdone_d;
    logic                ready_q;
    logic                we_d;
    logic [NIB_W-1:0]    ram_wd_d;

    // Decoding
    wire cmd_t             cmd_w      = cmd_t'(cmd_code);
    wire logic             take_w     = cmd_valid && ready_q;
    wire logic [PC_W-1:0]  rom_mask_w = rom_2k ? ROM_2K_MASK : ROM_FULL_MASK;
    wire logic [PC_W-1:0]  pc_inc_w   = pc_q + PC_W'(cmd_len);
    wire logic [PC_W-1:0]  branch_w   = {pc_inc_w[PC_W-1:PAGE_LO_W], cmd_operand[PAGE_LO_W-1:0]};
    wire logic [PC_W-1:0]  call_w     = {1'b0, cmd_operand[PC_W-2:0]};
    wire logic [PC_W-1:0]  vector_w   = VEC_BASE + {8'h00, irq_src, 1'b0};
    wire logic [RAM_AW-1:0] ptr_addr_w = {page_q, word_q};
    wire logic [RAM_AW-1:0] stk_base_w = {STACK_TOP_BITS, ram.rdata, STACK_LOW_BITS};
    wire logic [RAM_AW-1:0] lvl_base_w = {STACK_TOP_BITS, level_q, STACK_LOW_BITS};
    wire logic [3:0]       nib_pos_w  = {idx_q, 2'b00};
    wire logic [PC_W-1:0]  dc_full_w  = {ram.rdata, dc_q[7:0]};
    wire logic [PC_W-1:0]  lut_addr_w = {LOOKUP_TOP, carry_q, ram.rdata};
    wire logic             push_w     = (op_q == CMD_CALL) || (op_q == CMD_IRQ);
    wire logic             last_stk_w = (idx_q == LAST_STK_NIB);
    wire logic             last_dc_w  = (idx_q == LAST_DC_NIB);

    assign ram.addr  = buf_q;
    assign ram.we    = we_d;
    assign ram.wdata = ram_wd_d;

    always_comb begin
        state_d    = state_q;
        op_d       = op_q;
        idx_d      = idx_q;
        pc_d       = pc_q;
        target_d   = target_q;
        stk_d      = stk_q;
        level_d    = level_q;
        dc_d       = dc_q;
        buf_d      = buf_q;
        page_d     = page_q;
        word_d     = word_q;
        wr_d       = wr_q;
        wdata_d    = wdata_q;
        carry_d    = carry_q;
        acc_d      = acc_q;
        lut_d      = lut_q;
        flg_d      = flg_q;
        mrd_d      = mrd_q;
        acc_ld_d   = 1'b0;
        lut_ld_d   = 1'b0;
        flg_ld_d   = 1'b0;
        mdone_d    = 1'b0;
        we_d       = 1'b0;
        ram_wd_d   = stk_q[nib_pos_w +: NIB_W];
        rom_addr_d = rom_addr_q;
        case (state_q)
            S_IDLE: begin
                if (take_w) begin
                    op_d  = cmd_w;
                    idx_d = 2'h0;
                    case (cmd_w)
                        CMD_ADVANCE: begin
                            pc_d = pc_inc_w;
                        end
                        CMD_BRANCH_PAGE: begin
                            pc_d = cmd_cond ? branch_w : pc_inc_w;
                        end
                        CMD_JUMP: begin
                            pc_d = cmd_operand;
                        end
                        CMD_CALL: begin
                            stk_d    = {flags_in, pc_inc_w};
                            target_d = call_w;
                            buf_d    = SPW_ADDR;
                            state_d  = S_SPW_RD;
                        end
                        CMD_IRQ: begin
                            stk_d    = {flags_in, pc_q};
                            target_d = vector_w;
                            buf_d    = SPW_ADDR;
                            state_d  = S_SPW_RD;
                        end
                        CMD_RET, CMD_RETURN_FROM_IRQ: begin
                            buf_d   = SPW_ADDR;
                            state_d = S_SPW_RD;
                        end
                        CMD_TABLE_HIGH, CMD_TABLE_LOW: begin
                            buf_d   = DC_ADDR_LOW;
                            state_d = S_DC_RD;
                        end
                        CMD_LOOKUP: begin
                            carry_d = flags_in[3];
                            buf_d   = ptr_addr_w;
                            state_d = S_LUT_RD;
                        end
                        CMD_LOAD_PAGE: begin
                            page_d = cmd_operand[NIB_W-1:0];
                        end
                        CMD_LOAD_WORD: begin
                            word_d = cmd_operand[NIB_W-1:0];
                        end
                        CMD_MEM_PTR, CMD_MEM_IMM: begin
                            buf_d   = (cmd_w == CMD_MEM_PTR) ? ptr_addr_w : cmd_operand[RAM_AW-1:0];
                            wr_d    = cmd_write;
                            wdata_d = cmd_wdata;
                            state_d = S_MEM;
                        end
                        default: begin
                            op_d = CMD_NONE;
                        end
                    endcase
                end
            end
            S_SPW_RD: begin
                state_d = S_SPW_CAP;
            end
            S_SPW_CAP: begin
                if (push_w) begin
                    level_d = ram.rdata;
                    buf_d   = stk_base_w;
                    state_d = S_STK;
                end else begin
                    level_d = ram.rdata + LEVEL_STEP;
                    state_d = S_SPW_WR;
                end
            end
            S_SPW_WR: begin
                we_d = 1'b1;
                if (push_w) begin
                    ram_wd_d = level_q - LEVEL_STEP;
                    pc_d     = target_q;
                    state_d  = S_IDLE;
                end else begin
                    ram_wd_d = level_q;
                    buf_d    = lvl_base_w;
                    idx_d    = 2'h0;
                    state_d  = S_STK;
                end
            end
            S_STK: begin
                if (push_w) begin
                    we_d  = 1'b1;
                    idx_d = idx_q + IDX_STEP;
                    if (last_stk_w) begin
                        buf_d   = SPW_ADDR;
                        state_d = S_SPW_WR;
                    end else begin
                        buf_d = buf_q + ADDR_STEP;
                    end
                end else begin
                    state_d = S_STK_CAP;
                end
            end
            S_STK_CAP: begin
                stk_d[nib_pos_w +: NIB_W] = ram.rdata;
                idx_d = idx_q + IDX_STEP;
                buf_d = buf_q + ADDR_STEP;
                if (last_stk_w) begin
                    pc_d    = stk_q[PC_W-1:0];
                    state_d = S_IDLE;
                    if (op_q == CMD_RETURN_FROM_IRQ) begin
                        flg_d    = ram.rdata;
                        flg_ld_d = 1'b1;
                    end
                end else begin
                    state_d = S_STK;
                end
            end
            S_DC_RD: begin
                state_d = S_DC_CAP;
            end
            S_DC_CAP: begin
                dc_d[nib_pos_w +: NIB_W] = ram.rdata;
                if (last_dc_w) begin
                    rom_addr_d = dc_full_w & rom_mask_w;
                    state_d    = S_ROM;
                end else begin
                    idx_d   = idx_q + IDX_STEP;
                    buf_d   = buf_q + ADDR_STEP;
                    state_d = S_DC_RD;
                end
            end
            S_DC_WR: begin
                we_d     = 1'b1;
                ram_wd_d = dc_q[nib_pos_w +: NIB_W];
                idx_d    = idx_q + IDX_STEP;
                buf_d    = buf_q + ADDR_STEP;
                if (last_dc_w) begin
                    state_d = S_IDLE;
                end
            end
            S_LUT_RD: begin
                state_d = S_LUT_CAP;
            end
            S_LUT_CAP: begin
                rom_addr_d = lut_addr_w & rom_mask_w;
                state_d    = S_ROM;
            end
            S_ROM: begin
                state_d = S_ROM_CAP;
            end
            S_ROM_CAP: begin
                rom_addr_d = pc_q & rom_mask_w;
                state_d    = S_IDLE;
                if (op_q == CMD_LOOKUP) begin
                    lut_d    = rom_data;
                    lut_ld_d = 1'b1;
                end else begin
                    acc_d    = (op_q == CMD_TABLE_HIGH) ? rom_data[7:4] : rom_data[3:0];
                    acc_ld_d = 1'b1;
                    if (op_q == CMD_TABLE_HIGH) begin
                        dc_d    = dc_q + DC_STEP;
                        buf_d   = DC_ADDR_LOW;
                        idx_d   = 2'h0;
                        state_d = S_DC_WR;
                    end
                end
            end
            S_MEM: begin
                if (wr_q) begin
                    we_d     = 1'b1;
                    ram_wd_d = wdata_q;
                    mdone_d  = 1'b1;
                    state_d  = S_IDLE;
                end else begin
                    state_d = S_MEM_CAP;
                end
            end
            S_MEM_CAP: begin
                mrd_d   = ram.rdata;
                mdone_d = 1'b1;
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        // Fetch address tracks the counter whenever no ROM data read is pending
        if ((state_d != S_ROM) && (state_d != S_ROM_CAP)) begin
            rom_addr_d = pc_d & rom_mask_w;
        end
    end

    // Counter and fetch path
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_q       <= PC_RESET;
            rom_addr_q <= PC_RESET;
        end else begin
            pc_q       <= pc_d;
            rom_addr_q <= rom_addr_d;
        end
    end

    // Sequencing state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= S_IDLE;
            op_q     <= CMD_NONE;
            idx_q    <= 2'h0;
            ready_q  <= 1'b0;
            wr_q     <= 1'b0;
            acc_ld_q <= 1'b0;
            lut_ld_q <= 1'b0;
            flg_ld_q <= 1'b0;
            mdone_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            idx_q    <= idx_d;
            ready_q  <= (state_d == S_IDLE);
            wr_q     <= wr_d;
            acc_ld_q <= acc_ld_d;
            lut_ld_q <= lut_ld_d;
            flg_ld_q <= flg_ld_d;
            mdone_q  <= mdone_d;
        end
    end

    // Pointers and captured data
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            page_q   <= '0;
            word_q   <= '0;
            buf_q    <= '0;
            target_q <= '0;
            stk_q    <= '0;
            level_q  <= '0;
            dc_q     <= '0;
            wdata_q  <= '0;
            carry_q  <= 1'b0;
            acc_q    <= '0;
            lut_q    <= '0;
            flg_q    <= '0;
            mrd_q    <= '0;
        end else begin
            page_q   <= page_d;
            word_q   <= word_d;
            buf_q    <= buf_d;
            target_q <= target_d;
            stk_q    <= stk_d;
            level_q  <= level_d;
            dc_q     <= dc_d;
            wdata_q  <= wdata_d;
            carry_q  <= carry_d;
            acc_q    <= acc_d;
            lut_q    <= lut_d;
            flg_q    <= flg_d;
            mrd_q    <= mrd_d;
        end
    end

    data_ram u_ram (
        .ref_clk (ref_clk),
        .port    (ram)
    );

    bit_select u_bits (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .word_sel   (word_q),
        .bit_onehot (port_bit_sel)
    );

    assign cmd_ready          = ready_q;
    assign fetch_addr         = rom_addr_q;
    assign next_instr_counter = pc_q;
    assign page_select_reg    = page_q;
    assign word_select_reg    = word_q;
    assign ram_addr_buffer    = buf_q;
    assign acc_data           = acc_q;
    assign acc_load           = acc_ld_q;
    assign lookup_byte_out    = lut_q;
    assign lookup_load        = lut_ld_q;
    assign flags_out          = flg_q;
    assign flags_load         = flg_ld_q;
    assign mem_rdata          = mrd_q;
    assign mem_done           = mdone_q;
endmodule

// *** addr_core_checker.sv ***
// Port assertions for the addressing core.
// Assumes the command codes of addr_core_pkg and one clock domain.
`timescale 1ns/1ps
module addr_core_checker
    import addr_core_pkg::*;
(
    // Clock, reset and command
    input wire logic            ref_clk,
    input wire logic            reset_n,
    input wire logic            rom_2k,
    input wire logic            cmd_valid,
    input wire logic [3:0]      cmd_code,
    input wire logic [PC_W-1:0] cmd_operand,
    input wire logic [1:0]      cmd_len,
    input wire logic            cmd_cond,
    input wire logic [2:0]      irq_src,
    // Watched outputs
    input wire logic            cmd_ready,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic [PC_W-1:0] next_instr_counter,
    input wire logic [3:0]      word_select_reg,
    input wire logic [15:0]     port_bit_sel,
    input wire logic            acc_load
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [PC_W-1:0] br_q;
    logic [PC_W-1:0] tgt_q;
    wire take = cmd_valid && cmd_ready;
    wire [PC_W-1:0] pc_inc = next_instr_counter + PC_W'(cmd_len);
    wire [PC_W-1:0] tgt_d = (cmd_code == 4'h4) ? {1'b0, cmd_operand[10:0]} : VEC_BASE + {8'h00, irq_src, 1'b0};
    always_ff @(posedge ref_clk) begin
        br_q <= {pc_inc[11:6], cmd_operand[5:0]};
        tgt_q <= take ? tgt_d : tgt_q;
    end
    sequence call_taken; take && cmd_code == 4'h4; endsequence
    sequence irq_taken; take && cmd_code == 4'h5; endsequence
    sequence loaded; ##[1:16] (cmd_ready && next_instr_counter == tgt_q); endsequence
    a_reset_pc_zero: assert property ($rose(reset_n) |-> next_instr_counter == PC_RESET)
        else $error("counter not zero after reset");
    a_advance_by_len: assert property (take && cmd_code == 4'h1 |=> next_instr_counter == $past(pc_inc))
        else $error("advance wrong");
    a_branch_in_page: assert property (take && cmd_code == 4'h2 && cmd_cond |=> next_instr_counter == br_q)
        else $error("in-page branch wrong");
    a_call_target: assert property (call_taken |-> loaded)
        else $error("call target wrong");
    a_irq_vector: assert property (irq_taken |-> loaded)
        else $error("vector wrong");
    a_small_rom_mask: assert property (rom_2k && $past(rom_2k) |-> !fetch_addr[11])
        else $error("top fetch bit not masked");
    a_pin_one_hot: assert property (reset_n |=> port_bit_sel == (16'h0001 << $past(word_select_reg)))
        else $error("pin select wrong");
    a_table_answer: assert property (take && cmd_code == 4'h9 |-> ##[1:10] acc_load)
        else $error("table read late");
endmodule
bind addr_core addr_core_checker i_chk (.ref_clk, .reset_n, .rom_2k, .cmd_valid, .cmd_code, .cmd_operand, .cmd_len,
    .cmd_cond, .irq_src, .cmd_ready, .fetch_addr, .next_instr_counter, .word_select_reg, .port_bit_sel, .acc_load);

// *** addr_core_pkg.sv ***
// Constants, command codes and state codes for the addressing core.
// Assumes one 20 MHz system clock shared by every module that imports it.
package addr_core_pkg;

    // Widths
    localparam int PC_W      = 12;
    localparam int PAGE_LO_W = 6;
    localparam int NIB_W     = 4;
    localparam int RAM_AW    = 8;
    localparam int RAM_DEPTH = 256;
    localparam int ROM_DW    = 8;
    localparam int PORT_BITS = 16;

    // Program memory addresses
    localparam logic [11:0] PC_RESET      = 12'h000;
    localparam logic [11:0] VEC_BASE      = 12'h002;
    localparam logic [11:0] ROM_2K_MASK   = 12'h7FF;
    localparam logic [11:0] ROM_FULL_MASK = 12'hFFF;
    localparam logic [11:0] DC_STEP       = 12'h001;
    localparam logic [6:0]  LOOKUP_TOP    = 7'h7F;

    // Data memory addresses
    localparam logic [7:0] SPW_ADDR       = 8'hFF;
    localparam logic [7:0] DC_ADDR_LOW    = 8'hFC;
    localparam logic [1:0] STACK_TOP_BITS = 2'h3;
    localparam logic [1:0] STACK_LOW_BITS = 2'h0;
    localparam logic [1:0] LAST_STK_NIB   = 2'h3;
    localparam logic [1:0] LAST_DC_NIB    = 2'h2;
    localparam logic [3:0] LEVEL_STEP     = 4'h1;
    localparam logic [7:0] ADDR_STEP      = 8'h01;
    localparam logic [1:0] IDX_STEP       = 2'h1;

    typedef enum logic [3:0] {
        CMD_NONE        = 4'h0,
        CMD_ADVANCE     = 4'h1,
        CMD_BRANCH_PAGE = 4'h2,
        CMD_JUMP        = 4'h3,
        CMD_CALL        = 4'h4,
        CMD_IRQ         = 4'h5,
        CMD_RET         = 4'h6,
        CMD_RETURN_FROM_IRQ        = 4'h7,
        CMD_TABLE_HIGH  = 4'h8,
        CMD_TABLE_LOW   = 4'h9,
        CMD_LOOKUP      = 4'hA,
        CMD_LOAD_PAGE   = 4'hB,
        CMD_LOAD_WORD   = 4'hC,
        CMD_MEM_PTR     = 4'hD,
        CMD_MEM_IMM     = 4'hE
    } cmd_t;

    typedef enum logic [2:0] {
        IRQ_EXT_ONE   = 3'h0,
        IRQ_SERIAL    = 3'h1,
        IRQ_TIMER_ONE = 3'h2,
        IRQ_TIMER_TWO = 3'h3,
        IRQ_DIVIDER   = 3'h4,
        IRQ_EXT_TWO   = 3'h5
    } irq_src_t;

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_SPW_RD  = 4'h1,
        S_SPW_CAP = 4'h2,
        S_SPW_WR  = 4'h3,
        S_STK     = 4'h4,
        S_STK_CAP = 4'h5,
        S_DC_RD   = 4'h6,
        S_DC_CAP  = 4'h7,
        S_DC_WR   = 4'h8,
        S_ROM     = 4'h9,
        S_ROM_CAP = 4'hA,
        S_LUT_RD  = 4'hB,
        S_LUT_CAP = 4'hC,
        S_MEM     = 4'hD,
        S_MEM_CAP = 4'hE
    } state_t;

endpackage

// *** bit_select.sv ***
// Registered one-hot decode of the word pointer onto the sixteen port pins.
// Assumes the word pointer comes from a register of the same clock.
`timescale 1ns/1ps
module bit_select
    import addr_core_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // Pointer in, pin select out
    input  wire logic [NIB_W-1:0]     word_sel,
    output logic      [PORT_BITS-1:0] bit_onehot
);
    genvar i;
    generate
        for (i = 0; i < PORT_BITS; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    bit_onehot[i] <= 1'b0;
                end else begin
                    bit_onehot[i] <= (word_sel == NIB_W'(i));
                end
            end
        end
    endgenerate
endmodule

// *** data_ram.sv ***
// 256 x 4 data memory with registered read data.
// Assumes writes and reads share the single address from the core.
`timescale 1ns/1ps
module data_ram
    import addr_core_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Memory port
    ram_if.mem        port
);
    logic [NIB_W-1:0] mem_q [RAM_DEPTH];
    logic [NIB_W-1:0] rdata_q;

    // Contents are never reset, including the stack-level word
    always_ff @(posedge ref_clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
        rdata_q <= mem_q[port.addr];
    end

    assign port.rdata = rdata_q;
endmodule

// *** program_and_stack_addressing_bench.sv ***
// Random and corner-case bench for the addressing core.
// Assumes the command handshake and stack layout of the core.
`timescale 1ns/1ps
module program_and_stack_addressing_bench
    import addr_core_pkg::*;
();
    logic ref_clk = 1'b0, reset_n = 1'b0, rom_2k = 1'b0, cmd_valid = 1'b0, cmd_cond = 1'b1, cmd_write = 1'b0;
    logic [3:0] cmd_code = 4'h0, cmd_wdata = 4'h0, flags_in = 4'h0;
    logic [1:0] cmd_len = 2'h1;
    logic [2:0] irq_src = 3'h0;
    logic [11:0] cmd_operand = 12'h000, fetch_addr, next_instr_counter;
    logic [7:0] rom_data, ram_addr_buffer, lookup_byte_out;
    logic [3:0] page_select_reg, word_select_reg, acc_data, flags_out, mem_rdata;
    logic [15:0] port_bit_sel;
    logic cmd_ready, acc_load, lookup_load, flags_load, mem_done;
    logic [31:0] seed = 32'h51;
    int num_errors = 0, checks_done = 0;
    addr_core i_dut (.*);
    rom_model i_rom (.ref_clk, .fetch_addr, .rom_data);
    always #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] rom_exp(input logic [11:0] a);
        return (a[10:8] == 3'h5) ? 8'h00 : a[7:0] ^ {2{a[11:8]}};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [11:0] o, input logic [3:0] d = 4'h0, input logic w = 1'b0);
        int n;
        n = 0;
        cmd_code <= c;
        cmd_operand <= o;
        cmd_wdata <= d;
        cmd_write <= w;
        cmd_valid <= 1'b1;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 60);
        cmd_valid <= 1'b0;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 60);
        if (n >= 60) begin
            num_errors++;
            $display("unexpected hang at %0t", $time);
            finish_test();
        end
    endtask
    task automatic finish_test();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        logic [11:0] pc, t, o;
        logic [7:0] b;
        logic [3:0] f;
        logic [1:0] l;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(next_instr_counter, 12'h000);
        go(4'hE, 12'h0FF, 4'hC, 1'b1);
        for (int k = 0; k < 24; k++) begin
            t = 12'(rnd());
            if (k < 4) t[5:0] = 6'h3F;
            l = 2'(rnd() % 3 + 1);
            o = 12'(rnd());
            cmd_len <= l;
            go(4'h3, t);
            pc = t + 12'(l);
            cmd_cond <= k[0];
            go(4'h2, o);
            if (k[0]) pc[5:0] = o[5:0];
            chk(next_instr_counter, pc);
            pc = pc + 12'(l);
            go(4'h1, 12'h000);
            chk(next_instr_counter, pc);
        end
        o = 12'(rnd());
        f = 4'(rnd());
        flags_in <= f;
        go(4'h4, o);
        chk(next_instr_counter, {1'b0, o[10:0]});
        pc = pc + 12'(l);
        go(4'hE, 12'h0FF);
        chk(mem_rdata, 4'hB);
        for (int k = 0; k < 4; k++) begin
            go(4'hE, 12'h0F0 + 12'(k));
            chk(mem_rdata, (k == 3) ? f : pc[4*k +: 4]);
        end
        go(4'h6, 12'h000);
        chk(next_instr_counter, pc);
        go(4'hE, 12'h0FF);
        chk(mem_rdata, 4'hC);
        for (int s = 0; s < 6; s++) begin
            f = 4'(rnd());
            flags_in <= f;
            irq_src <= 3'(s);
            go(4'h5, 12'h000);
            chk(next_instr_counter, 12'h002 + 12'(2 * s));
            flags_in <= ~f;
            go(4'h7, 12'h000);
            chk(next_instr_counter, pc);
            chk(flags_out, f);
        end
        for (int k = 0; k < 4; k++) begin
            t = 12'(rnd());
            rom_2k <= k[1];
            for (int j = 0; j < 3; j++) go(4'hE, 12'h0FC + 12'(j), t[4*j +: 4], 1'b1);
            b = rom_exp(t & {~k[1], 11'h7FF});
            go(4'h9, 12'h000);
            chk(acc_data, b[3:0]);
            go(4'h8, 12'h000);
            chk(acc_data, b[7:4]);
            t = t + 12'h001;
            go(4'hE, 12'h0FC);
            chk(mem_rdata, t[3:0]);
            go(4'hB, 12'(k));
            go(4'hC, {8'h00, t[3:0]});
            f = 4'(rnd());
            go(4'hD, 12'h000, f, 1'b1);
            chk({page_select_reg, ram_addr_buffer}, {4'(k), 4'(k), t[3:0]});
            flags_in <= {k[0], 3'h0};
            go(4'hA, 12'h000);
            chk(lookup_byte_out, rom_exp({7'h7F, k[0], f} & {~k[1], 11'h7FF}));
            chk(port_bit_sel, 16'h0001 << t[3:0]);
        end
        finish_test();
    end
endmodule

// *** ram_if.sv ***
// Data-memory port between the addressing core and the nibble RAM.
// Assumes read data follow the address by one clock.
`timescale 1ns/1ps
interface ram_if;
    import addr_core_pkg::*;
    logic [RAM_AW-1:0] addr;
    logic              we;
    logic [NIB_W-1:0]  wdata;
    logic [NIB_W-1:0]  rdata;
    modport core (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// *** rom_model.sv ***
// Program ROM model: fixed byte pattern, two regions left blank.
// Assumes the core samples rom_data one clock after fetch_addr.
`timescale 1ns/1ps
module rom_model
    import addr_core_pkg::*;
(
    // Fetch port
    input  wire logic              ref_clk,
    input  wire logic [PC_W-1:0]   fetch_addr,
    output logic      [ROM_DW-1:0] rom_data
);
    always_ff @(posedge ref_clk) begin
        rom_data <= (fetch_addr[10:8] == 3'h5) ? 8'h00 : fetch_addr[7:0] ^ {2{fetch_addr[11:8]}};
    end
endmodule
